// >>> verilog/tws_params.svh
/*
 * Constants for the three-wire serial load port: word size, address field,
 * destination indices and host timing.
 * Assumes inclusion by bare name from design files of this block.
 */
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

`define TWS_WORD_BITS 24
`define TWS_BYTE_BITS 8
`define TWS_BYTES_PER_WORD 3
`define TWS_ADDR_LSB 0
`define TWS_ADDR_BITS 3
`define TWS_NUM_DEST 8
`define TWS_FREQ_ADDR 3'h0
`define TWS_DBUF_LO_ADDR 3'h1
`define TWS_DBUF_HI_ADDR 3'h2
`define TWS_MUX_ADDR 3'h3
`define TWS_MUX_SEL_LSB 3
`define TWS_MUX_SEL_BITS 2
`define TWS_MUX_RESET_VAL 2'h0
`define TWS_CLK_SYS_HZ 10000000
`define TWS_SCLK_MAX_HZ 33000000
`define TWS_SCLK_HALF_CYCLES 4

`endif

// >>> verilog/tws_pkg.sv
/*
 * Types shared by both ends of the three-wire serial load port.
 * Assumes the constants header is compiled alongside.
 */
`include "tws_params.svh"

package tws_pkg;
    typedef enum logic [1:0] {
        TWS_MUX_LOW,
        TWS_MUX_LOCK,
        TWS_MUX_HIGH,
        TWS_MUX_PENDING
    } tws_mux_sel_t;

    typedef enum {
        TWS_H_IDLE,
        TWS_H_LOW,
        TWS_H_HIGH,
        TWS_H_GAP,
        TWS_H_STROBE
    } tws_host_state_t;
endpackage

// >>> verilog/tws_link_if.sv
/*
 * Link between the serial host and the synthesizer load port.
 * Assumes all wires are driven by the host except the status output.
 */
`timescale 1ns/1ps
`default_nettype none

interface tws_link_if;
    logic sclk;              // Serial clock, host driven
    logic sdata;             // Serial data, host driven
    logic latch_strobe;      // Latch strobe, host driven
    logic status_mux_output; // Status output, device driven

    modport device (
        input sclk,
        input sdata,
        input latch_strobe,
        output status_mux_output
    );
    modport host (
        output sclk,
        output sdata,
        output latch_strobe,
        input status_mux_output
    );
endinterface

`default_nettype wire

// >>> verilog/tws_host.sv
/*
 * Host end: shifts 24-bit words MSB first as three bytes, raises the latch
 * strobe afterwards, and samples the status output.
 * Assumes clk_sys at 10 MHz; the serial clock is divided from it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"

module tws_host #(
    parameter int HALF_CYCLES = `TWS_SCLK_HALF_CYCLES
) (
    input wire logic clk_sys,                     // System clock
    input wire logic resetn,                      // Async reset, active low
    input wire logic req_valid,                   // Word request
    input wire logic req_hold,                    // Delay the strobe while high
    input wire logic [`TWS_WORD_BITS-1:0] req_word, // Word to send
    output logic req_ready,                       // Idle, request accepted
    output logic done,                            // Pulse when strobe rises
    output logic status_level,                    // Synchronised status
    tws_link_if.host link                         // Serial link
);
    localparam int SCLK_MAX_MIN_HALF =
        (`TWS_CLK_SYS_HZ + 2 * `TWS_SCLK_MAX_HZ - 1) / (2 * `TWS_SCLK_MAX_HZ);
    localparam int HALF = (HALF_CYCLES < SCLK_MAX_MIN_HALF) ? SCLK_MAX_MIN_HALF :
        ((HALF_CYCLES < 1) ? 1 : HALF_CYCLES);

    tws_pkg::tws_host_state_t state_reg, state_next;
    logic [15:0] div_reg;
    logic [`TWS_WORD_BITS-1:0] sh_reg;
    logic [4:0] bit_reg;
    logic sclk_reg, sdata_reg, le_reg, ready_reg, done_reg;
    logic st_s1, st_s2;
    wire tick = (div_reg == 16'(HALF - 1));
    wire byte_end = (bit_reg[2:0] == 3'h7);
    wire word_end = (bit_reg == 5'(`TWS_WORD_BITS - 1));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            tws_pkg::TWS_H_IDLE: if (req_valid) state_next = tws_pkg::TWS_H_LOW;
            tws_pkg::TWS_H_LOW: if (tick) state_next = tws_pkg::TWS_H_HIGH;
            tws_pkg::TWS_H_HIGH: begin
                if (tick) begin
                    if (word_end) state_next = tws_pkg::TWS_H_STROBE;
                    else if (byte_end) state_next = tws_pkg::TWS_H_GAP;
                    else state_next = tws_pkg::TWS_H_LOW;
                end
            end
            tws_pkg::TWS_H_GAP: if (tick) state_next = tws_pkg::TWS_H_LOW;
            tws_pkg::TWS_H_STROBE: if (tick && !req_hold) state_next = tws_pkg::TWS_H_IDLE;
            default: state_next = tws_pkg::TWS_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= tws_pkg::TWS_H_IDLE;
            div_reg <= 16'h0000;
            sh_reg <= '0;
            bit_reg <= 5'h00;
            sclk_reg <= 1'b0;
            sdata_reg <= 1'b0;
            le_reg <= 1'b1;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            st_s1 <= 1'b0;
            st_s2 <= 1'b0;
        end else begin
            state_reg <= state_next;
            st_s1 <= link.status_mux_output;
            st_s2 <= st_s1;
            done_reg <= 1'b0;
            ready_reg <= (state_next == tws_pkg::TWS_H_IDLE);
            div_reg <= (state_reg == tws_pkg::TWS_H_IDLE || tick) ? 16'h0000 : div_reg + 16'h0001;
            if (state_reg == tws_pkg::TWS_H_IDLE && req_valid) begin
                sh_reg <= req_word << 1;
                sdata_reg <= req_word[`TWS_WORD_BITS-1];
                bit_reg <= 5'h00;
                le_reg <= 1'b0;
            end
            if (state_reg == tws_pkg::TWS_H_LOW && tick)
                sclk_reg <= 1'b1;
            if (state_reg == tws_pkg::TWS_H_HIGH && tick) begin
                sclk_reg <= 1'b0;
                if (!word_end) begin
                    sdata_reg <= sh_reg[`TWS_WORD_BITS-1];
                    sh_reg <= sh_reg << 1;
                    bit_reg <= bit_reg + 5'h01;
                end
            end
            if (state_reg == tws_pkg::TWS_H_STROBE && tick && !req_hold) begin
                le_reg <= 1'b1;
                done_reg <= 1'b1;
            end
        end
    end

    assign link.sclk = sclk_reg;
    assign link.sdata = sdata_reg;
    assign link.latch_strobe = le_reg;
    assign req_ready = ready_reg;
    assign done = done_reg;
    assign status_level = st_s2;
endmodule // tws_host

`default_nettype wire

// >>> verilog/tws_device.sv
/*
 * Device end: write-only serial load port of the synthesizer. Samples the
 * link pins with clk_sys, shifts on serial clock rises, latches on strobe rise.
 * Assumes serial clock half periods of at least two clk_sys cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"

// Summary of operation
// - Sample data each clock rise into 24 bits
// - Strobe rise copies word to addressed register
// - Host serial clock at most 33 MHz
// - Host holds strobe low while shifting
// - Byte hosts send three bytes, then strobe
// - Host presents data before rising edge
// - Status output shows lock when selected
// - Write only, no read-back path
// - Double-buffered settings apply on frequency load
// - Host may delay strobe until switch time
module tws_device #(
    parameter int WORD_BITS = `TWS_WORD_BITS,
    parameter int ADDR_BITS = `TWS_ADDR_BITS
) (
    input wire logic clk_sys,                  // System clock
    input wire logic resetn,                   // Async reset, active low
    input wire logic lock_detect,              // Loop lock state, same domain
    output logic [WORD_BITS-1:0] freq_word,    // Active frequency word
    output logic [WORD_BITS-1:0] active_lo,    // Active double-buffered word 1
    output logic [WORD_BITS-1:0] active_hi,    // Active double-buffered word 2
    output logic [WORD_BITS-1:0] mux_word,     // Immediate control word
    output logic load_pulse,                   // Pulse when frequency applied
    tws_link_if.device link                    // Serial link
);
    localparam int NUM_USED = 4; // Addresses 0 to 3 own a register
    localparam int FREQ_IDX = 0;
    localparam int LO_IDX = 1;
    localparam int HI_IDX = 2;
    localparam int MUX_IDX = 3;

    // Two stages settle each pin; the third on the edge pins only finds edges
    logic [2:0] sclk_sy;
    logic [2:0] le_sy;
    logic [1:0] sd_sy;

    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] dest_reg [NUM_USED];
    logic [WORD_BITS-1:0] act_lo_reg;
    logic [WORD_BITS-1:0] act_hi_reg;
    logic [WORD_BITS-1:0] mux_out_reg;
    logic load_reg;
    logic status_reg;
    wire [NUM_USED-1:0] dest_hit;

    function automatic logic [ADDR_BITS-1:0] dest_addr(input int idx);
        logic [ADDR_BITS-1:0] a;
        case (idx)
            FREQ_IDX: begin
                a = ADDR_BITS'(`TWS_FREQ_ADDR);
            end
            LO_IDX: begin
                a = ADDR_BITS'(`TWS_DBUF_LO_ADDR);
            end
            HI_IDX: begin
                a = ADDR_BITS'(`TWS_DBUF_HI_ADDR);
            end
            default: begin
                a = ADDR_BITS'(`TWS_MUX_ADDR);
            end
        endcase
        dest_addr = a;
    endfunction

    // Unlisted addresses match no destination, so their strobes are dropped
    function automatic logic addr_match(input logic [ADDR_BITS-1:0] a, input int idx);
        addr_match = (a == dest_addr(idx));
    endfunction

    // The last selector code drives low; it is kept free for later use
    function automatic logic status_pick(input logic [1:0] sel, input logic lock);
        logic s;
        case (sel)
            tws_pkg::TWS_MUX_LOCK: begin
                s = lock;
            end
            tws_pkg::TWS_MUX_HIGH: begin
                s = 1'b1;
            end
            default: begin
                s = 1'b0;
            end
        endcase
        status_pick = s;
    endfunction

    wire sclk_rise = sclk_sy[1] & ~sclk_sy[2];
    wire le_rise = le_sy[1] & ~le_sy[2];
    wire [ADDR_BITS-1:0] addr = shift_reg[`TWS_ADDR_LSB +: ADDR_BITS];
    wire [WORD_BITS-1:0] shift_next = {shift_reg[WORD_BITS-2:0], sd_sy[1]};
    wire hit_freq = dest_hit[FREQ_IDX];
    wire [WORD_BITS-1:0] pend_lo = dest_reg[LO_IDX];
    wire [WORD_BITS-1:0] pend_hi = dest_reg[HI_IDX];
    wire [WORD_BITS-1:0] mux_cur = dest_reg[MUX_IDX];
    wire [1:0] mux_sel = mux_cur[`TWS_MUX_SEL_LSB +: `TWS_MUX_SEL_BITS];
    wire status_next = status_pick(mux_sel, lock_detect);

    genvar g;
    generate
        for (g = 0; g < NUM_USED; g++) begin : g_dest
            assign dest_hit[g] = le_rise && addr_match(addr, g);
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sclk_sy <= 3'h0;
        end else begin
            sclk_sy <= {sclk_sy[1:0], link.sclk};
        end
    end

    // Idle strobe level, so the release of reset shows no rise
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            le_sy <= 3'h7;
        end else begin
            le_sy <= {le_sy[1:0], link.latch_strobe};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sd_sy <= 2'h0;
        end else begin
            sd_sy <= {sd_sy[0], link.sdata};
        end
    end

    // Data stays two samples behind its pin, matching the clock path delay
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shift_reg <= '0;
        end else if (sclk_rise) begin
            shift_reg <= shift_next;
        end
    end

    // Words for addresses 1 and 2 sit here as pending settings
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_USED; i++) begin
                dest_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_USED; i++) begin
                if (dest_hit[i]) begin
                    dest_reg[i] <= shift_reg;
                end
            end
        end
    end

    // Pending words take effect only when the frequency word lands
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            act_lo_reg <= '0;
            act_hi_reg <= '0;
        end else if (hit_freq) begin
            act_lo_reg <= pend_lo;
            act_hi_reg <= pend_hi;
        end
    end

    // Marks the cycle after the frequency word lands
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            load_reg <= 1'b0;
        end else begin
            load_reg <= hit_freq;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mux_out_reg <= '0;
        end else begin
            mux_out_reg <= mux_cur;
        end
    end

    // Registered so the pin never shows decode glitches
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
        end
    end

    assign freq_word = dest_reg[FREQ_IDX];
    assign active_lo = act_lo_reg;
    assign active_hi = act_hi_reg;
    assign mux_word = mux_out_reg;
    assign load_pulse = load_reg;
    // Only the status line leaves toward the host; contents never do
    assign link.status_mux_output = status_reg;
endmodule // tws_device

`default_nettype wire

// >>> testbench/tws_link_asserts.sv
/* Checker for the serial load link: clock halves, framing, bit count.
   Assumes a host divider of 4 clk_sys cycles per serial clock half. */
`timescale 1ns/1ps
`default_nettype none
module tws_link_asserts (
    input wire logic clk_sys, // System clock
    input wire logic resetn, // Async reset, active low
    input wire logic sclk, // Serial clock
    input wire logic sdata, // Serial data
    input wire logic latch_strobe, // Latch strobe
    input wire logic status_mux_output // Status output
);
    logic [5:0] bit_cnt_reg;
    logic sclk_reg;
    wire logic sclk_rise = sclk && !sclk_reg;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_reg <= 6'h00;
            sclk_reg <= 1'b0;
        end else begin
            sclk_reg <= sclk;
            bit_cnt_reg <= latch_strobe ? 6'h00 : bit_cnt_reg + {5'h00, sclk_rise};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_shift_strobe_low; sclk |-> !latch_strobe; endproperty
    a_shift_strobe_low: assert property (p_shift_strobe_low)
        else $error("serial clock high while strobe is up");
    property p_high_half; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
    a_high_half: assert property (p_high_half)
        else $error("serial clock high half not 4 cycles");
    property p_low_half; $fell(sclk) |-> !sclk[*4]; endproperty
    a_low_half: assert property (p_low_half)
        else $error("serial clock low half too short");
    property p_data_stable; sclk |-> $stable(sdata); endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("data moved while serial clock high");
    property p_first_half; $fell(latch_strobe) |-> !sclk[*4] ##1 sclk; endproperty
    a_first_half: assert property (p_first_half)
        else $error("first clock rise not one half after strobe fall");
    property p_strobe_late; $rose(latch_strobe) |-> !sclk && !$past(sclk, 4); endproperty
    a_strobe_late: assert property (p_strobe_late)
        else $error("strobe rose too soon after last clock");
    property p_word_bits; $rose(latch_strobe) |-> bit_cnt_reg == 6'h18; endproperty
    a_word_bits: assert property (p_word_bits)
        else $error("strobe rose after a count other than 24");
    property p_byte_gap;
        $fell(sclk) && (bit_cnt_reg == 6'h08 || bit_cnt_reg == 6'h10) |-> !sclk[*8];
    endproperty
    a_byte_gap: assert property (p_byte_gap)
        else $error("no idle half between bytes");
    cover property ($rose(latch_strobe));
    cover property ($fell(sclk) && bit_cnt_reg == 6'h10);
    cover property ($rose(status_mux_output));
endmodule // tws_link_asserts
`default_nettype wire

// >>> testbench/tws_load_port_bench.sv
/* Bench joining host and device ends over the link; table of words, then
   strobe hold and mid-frame reset. Assumes default host divider of 4. */
`timescale 1ns/1ps
`default_nettype none
module tws_load_port_bench;
    typedef struct {logic [23:0] w; logic lk; logic [23:0] ef, el, eh; logic es;} tws_row_t;
    logic clk_sys = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_hold = 1'b0, lock_detect = 1'b0;
    logic [23:0] req_word = 24'h000000, wire_word;
    logic req_ready, done, status_level, load_pulse;
    logic [23:0] freq_word, active_lo, active_hi, mux_word;
    int failures = 0, n_checks = 0, n_loads = 0;
    tws_row_t rows [11] = '{
        '{24'habcd11, 1'b0, 24'h000000, 24'h000000, 24'h000000, 1'b0},
        '{24'h5a5a52, 1'b0, 24'h000000, 24'h000000, 24'h000000, 1'b0},
        '{24'h123458, 1'b0, 24'h123458, 24'habcd11, 24'h5a5a52, 1'b0},
        '{24'hfffff9, 1'b0, 24'h123458, 24'habcd11, 24'h5a5a52, 1'b0},
        '{24'h00000c, 1'b1, 24'h123458, 24'habcd11, 24'h5a5a52, 1'b0},
        '{24'h800000, 1'b0, 24'h800000, 24'hfffff9, 24'h5a5a52, 1'b0},
        '{24'h00000b, 1'b1, 24'h800000, 24'hfffff9, 24'h5a5a52, 1'b1},
        '{24'h00000b, 1'b0, 24'h800000, 24'hfffff9, 24'h5a5a52, 1'b0},
        '{24'h000013, 1'b0, 24'h800000, 24'hfffff9, 24'h5a5a52, 1'b1},
        '{24'h00001b, 1'b1, 24'h800000, 24'hfffff9, 24'h5a5a52, 1'b0},
        '{24'h000003, 1'b1, 24'h800000, 24'hfffff9, 24'h5a5a52, 1'b0}};
    always #50 clk_sys = ~clk_sys;
    tws_link_if link();
    tws_host i_tws_host (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid),
        .req_hold(req_hold), .req_word(req_word), .req_ready(req_ready), .done(done),
        .status_level(status_level), .link(link));
    tws_device i_tws_device (.clk_sys(clk_sys), .resetn(resetn), .lock_detect(lock_detect),
        .freq_word(freq_word), .active_lo(active_lo), .active_hi(active_hi),
        .mux_word(mux_word),
        .load_pulse(load_pulse), .link(link));
    tws_link_asserts i_tws_link_asserts (.clk_sys(clk_sys), .resetn(resetn), .sclk(link.sclk),
        .sdata(link.sdata), .latch_strobe(link.latch_strobe),
        .status_mux_output(link.status_mux_output));
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic start(input logic [23:0] w);
        for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk_sys);
        check("ready", {23'h0, req_ready}, 24'h000001);
        req_word = w;
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask
    task automatic finish();
        for (int i = 0; i < 600 && done !== 1'b1; i++) @(negedge clk_sys);
        check("done", {23'h0, done}, 24'h000001);
        repeat (8) @(negedge clk_sys);
    endtask
    // Rebuild the word from the wire so bit order is judged independently
    always @(posedge link.sclk) wire_word = {wire_word[22:0], link.sdata};
    always @(posedge link.latch_strobe) if (resetn === 1'b1) check("wire word", wire_word, req_word);
    always @(negedge clk_sys) if (load_pulse === 1'b1) n_loads++;
    initial begin
        #2000000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        foreach (rows[k]) begin
            lock_detect = rows[k].lk;
            start(rows[k].w);
            finish();
            check("freq_word", freq_word, rows[k].ef);
            check("active_lo", active_lo, rows[k].el);
            check("active_hi", active_hi, rows[k].eh);
            check("status", {23'h0, status_level}, {23'h0, rows[k].es});
        end
        check("mux_word", mux_word, 24'h000003);
        req_hold = 1'b1;
        start(24'h0f0f08);
        repeat (300) @(negedge clk_sys);
        check("held freq_word", freq_word, 24'h800000);
        check("held loads", 24'(n_loads), 24'h000002);
        check("held ready", {23'h0, req_ready}, 24'h000000);
        req_hold = 1'b0;
        finish();
        check("released freq_word", freq_word, 24'h0f0f08);
        check("released loads", 24'(n_loads), 24'h000003);
        start(24'h777770);
        repeat (100) @(negedge clk_sys);
        resetn = 1'b0;
        @(negedge clk_sys);
        check("reset freq_word", freq_word, 24'h000000);
        check("idle strobe", {23'h0, link.latch_strobe}, 24'h000001);
        check("idle sclk", {23'h0, link.sclk}, 24'h000000);
        check("reset ready", {23'h0, req_ready}, 24'h000000);
        check("reset mux_word", mux_word, 24'h000000);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        start(24'h654320);
        finish();
        check("after reset freq_word", freq_word, 24'h654320);
        check("after reset lo", active_lo, 24'h000000);
        tally_and_finish();
    end
endmodule // tws_load_port_bench
`default_nettype wire
